// [src/iso_consts.svh]
// Overview of operation
// - increment reads the operand byte, adds one, updates zero, one instruction cycle
// - for the increments, destination 0 writes accumulator only; destination 1 writes memory byte only; literal or always writes the accumulator
// - increment-and-skip adds one, stores to destination, leaves every flag alone
// - zero skip result discards the next fetched instruction as a nop, two cycles
// - literal or merges the literal into the accumulator and updates zero
`ifndef ISO_CONSTS_SVH
`define ISO_CONSTS_SVH

// ----------------------------------------
// widths and values
// ----------------------------------------
`define ISO_DATA_W 8
`define ISO_ADDR_W 8
`define ISO_ACC_RST 8'h00
`define ISO_ZERO_RST 1'b0
`define ISO_INC_STEP 8'h01
`define ISO_ZERO_VAL 8'h00
`define ISO_DEST_ACC 1'b0
`define ISO_DEST_MEM 1'b1

`endif

// [src/iso_pkg.sv]
package iso_pkg;
  typedef enum logic [1:0] {
    iso_nop_op,
    iso_increment_operand_op,
    iso_increment_skip_on_zero_op,
    iso_or_literal_into_accumulator_op
  } iso_op_t;

  typedef enum logic [1:0] {
    iso_st_idle,
    iso_st_exec,
    iso_st_skip
  } iso_state_t;
endpackage

// [src/iso_alu.sv]
`timescale 1ns/1ps
`include "iso_consts.svh"

module iso_alu (
  input wire iso_pkg::iso_op_t op_i,
  input wire logic [`ISO_DATA_W-1:0] mem_i,
  input wire logic [`ISO_DATA_W-1:0] acc_i,
  input wire logic [`ISO_DATA_W-1:0] lit_i,
  output logic [`ISO_DATA_W-1:0] res_o,
  output logic res_zero_o
);
  // ----------------------------------------
  // result select
  // ----------------------------------------
  wire logic is_or;
  wire logic [`ISO_DATA_W-1:0] inc_res;
  wire logic [`ISO_DATA_W-1:0] or_res;

  assign is_or = (op_i == iso_pkg::iso_or_literal_into_accumulator_op);
  assign inc_res = `ISO_DATA_W'(mem_i + `ISO_INC_STEP);
  assign or_res = acc_i | lit_i;
  assign res_o = is_or ? or_res : inc_res;
  assign res_zero_o = (res_o == `ISO_ZERO_VAL);
endmodule

// [src/iso_exec.sv]
`timescale 1ns/1ps
`include "iso_consts.svh"

module iso_exec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire iso_pkg::iso_op_t instr_op_i,
  input wire logic instr_dest_i,
  input wire logic [`ISO_ADDR_W-1:0] instr_addr_i,
  input wire logic [`ISO_DATA_W-1:0] instr_lit_i,
  input wire logic [`ISO_DATA_W-1:0] mem_rdata_i,
  output logic instr_ready_o,
  output logic [`ISO_ADDR_W-1:0] mem_addr_o,
  output logic [`ISO_DATA_W-1:0] mem_wdata_o,
  output logic mem_we_o,
  output logic [`ISO_DATA_W-1:0] acc_o,
  output logic zero_o,
  output logic skip_o,
  output logic done_o
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  iso_pkg::iso_state_t state_q;
  iso_pkg::iso_op_t op_q;
  logic dest_q;
  logic [`ISO_DATA_W-1:0] lit_q;
  logic ready_q;
  logic [`ISO_ADDR_W-1:0] addr_q;
  logic [`ISO_DATA_W-1:0] wdata_q;
  logic we_q;
  logic [`ISO_DATA_W-1:0] acc_q;
  logic zero_q;
  logic skip_q;
  logic done_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic [`ISO_DATA_W-1:0] res;
  wire logic res_zero;
  wire logic in_idle;
  wire logic in_exec;
  wire logic in_skip;
  wire logic take;
  wire logic is_inc;
  wire logic is_incsz;
  wire logic is_or;
  wire logic any_inc;
  wire logic to_mem;
  wire logic to_acc;
  wire logic upd_zero;
  wire logic do_skip;

  iso_alu u_alu (
    .op_i(op_q),
    .mem_i(mem_rdata_i),
    .acc_i(acc_q),
    .lit_i(lit_q),
    .res_o(res),
    .res_zero_o(res_zero)
  );

  assign in_idle = (state_q == iso_pkg::iso_st_idle);
  assign in_exec = (state_q == iso_pkg::iso_st_exec);
  assign in_skip = (state_q == iso_pkg::iso_st_skip);
  assign take = instr_valid_i && ready_q;
  assign is_inc = (op_q == iso_pkg::iso_increment_operand_op);
  assign is_incsz = (op_q == iso_pkg::iso_increment_skip_on_zero_op);
  assign is_or = (op_q == iso_pkg::iso_or_literal_into_accumulator_op);
  assign any_inc = is_inc || is_incsz;
  assign to_mem = in_exec && any_inc && (dest_q == `ISO_DEST_MEM);
  assign to_acc = in_exec && ((any_inc && (dest_q == `ISO_DEST_ACC)) || is_or);
  assign upd_zero = in_exec && (is_inc || is_or);
  assign do_skip = in_exec && is_incsz && res_zero;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= iso_pkg::iso_st_idle;
      ready_q <= 1'b1;
      skip_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        iso_pkg::iso_st_idle: begin
          if (take) begin
            state_q <= iso_pkg::iso_st_exec;
            ready_q <= 1'b0;
          end
        end
        iso_pkg::iso_st_exec: begin
          ready_q <= 1'b1;
          if (do_skip) begin
            state_q <= iso_pkg::iso_st_skip;
            skip_q <= 1'b1;
          end else begin
            state_q <= iso_pkg::iso_st_idle;
            done_q <= 1'b1;
          end
        end
        iso_pkg::iso_st_skip: begin
          if (take) begin
            state_q <= iso_pkg::iso_st_idle;
            skip_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= iso_pkg::iso_st_idle;
          ready_q <= 1'b1;
          skip_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // instruction latch
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      op_q <= iso_pkg::iso_nop_op;
      dest_q <= `ISO_DEST_ACC;
      lit_q <= `ISO_ACC_RST;
      addr_q <= '0;
    end else if (take && in_idle) begin
      op_q <= instr_op_i;
      dest_q <= instr_dest_i;
      lit_q <= instr_lit_i;
      addr_q <= instr_addr_i;
    end
  end

  // ----------------------------------------
  // write-back
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_q <= `ISO_ACC_RST;
      zero_q <= `ISO_ZERO_RST;
      we_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      we_q <= to_mem;
      if (to_mem) begin
        wdata_q <= res;
      end
      if (to_acc) begin
        acc_q <= res;
      end
      if (upd_zero) begin
        zero_q <= res_zero;
      end
    end
  end

  assign instr_ready_o = ready_q;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;
  assign mem_we_o = we_q;
  assign acc_o = acc_q;
  assign zero_o = zero_q;
  assign skip_o = skip_q;
  assign done_o = done_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_INC_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec && is_inc |=> done_o && in_idle && zero_o == $past(res_zero))
    else $error("increment did not finish in one cycle with zero updated");

  AST_DEST_MEM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    to_mem |=> mem_we_o && mem_wdata_o == `ISO_DATA_W'($past(mem_rdata_i) + 8'h01)
      && acc_o == $past(acc_o))
    else $error("memory destination wrote wrong data or touched accumulator");

  AST_DEST_ACC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec && any_inc && dest_q == `ISO_DEST_ACC
      |=> !mem_we_o && acc_o == `ISO_DATA_W'($past(mem_rdata_i) + 8'h01))
    else $error("accumulator destination wrong or memory written");

  AST_SKIP_NO_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec && is_incsz |=> zero_o == $past(zero_o))
    else $error("increment-and-skip changed the zero flag");

  AST_SKIP_TWO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_skip |=> skip_o && instr_ready_o && !done_o && in_skip)
    else $error("zero skip did not wait for the instruction to discard");

  AST_SKIP_DISCARD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_skip && instr_valid_i |=> done_o && !skip_o && in_idle && !mem_we_o
      && acc_o == $past(acc_o) && zero_o == $past(zero_o))
    else $error("discarded instruction changed state or skip did not end");

  AST_READY_EXEC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec |-> !instr_ready_o)
    else $error("ready high during the execute cycle");

  AST_NO_SKIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec && is_incsz && !res_zero |=> done_o && !skip_o)
    else $error("nonzero increment-and-skip did not finish in one cycle");

  AST_OR_LIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec && is_or |=> acc_o == ($past(acc_o) | $past(lit_q)) && done_o && !mem_we_o)
    else $error("literal or gave a wrong accumulator");

  AST_ZERO_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    upd_zero |=> zero_o == ($past(res) == 8'h00))
    else $error("zero flag does not match the result");

  COV_SKIP: cover property (@(posedge clk_i) disable iff (!rst_n_i) do_skip ##1 skip_o);
  COV_WRAP: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    in_exec && is_inc && mem_rdata_i == 8'hFF);
  COV_OR: cover property (@(posedge clk_i) disable iff (!rst_n_i) in_exec && is_or);
  COV_MEM_WRITE: cover property (@(posedge clk_i) disable iff (!rst_n_i) to_mem ##1 mem_we_o);
  COV_DISCARD: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    in_skip && instr_valid_i ##1 done_o);
endmodule

// [verification/iso_mem_model.sv]
`timescale 1ns/1ps

module iso_mem_model (
  input wire logic clk_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  output logic [7:0] rdata_o
);
  // ----------------------------------------
  // data memory, read without delay
  // ----------------------------------------
  logic [7:0] mem_q [256];

  assign rdata_o = mem_q[addr_i];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end
endmodule

// [verification/tb_incr_skip_or_literal_exec.sv]
`timescale 1ns/1ps

module tb_incr_skip_or_literal_exec;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic vld = 1'b0;
  iso_pkg::iso_op_t opc = iso_pkg::iso_nop_op;
  logic dst = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] lit = 8'h00;
  logic [7:0] rdat, madr, wdat, acc;
  logic rdy, we, zero, skip, done;
  int bad_count = 0;
  int checks_done = 0;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  iso_exec i_iso_exec (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(vld),
    .instr_op_i(opc), .instr_dest_i(dst), .instr_addr_i(adr), .instr_lit_i(lit),
    .mem_rdata_i(rdat), .instr_ready_o(rdy), .mem_addr_o(madr), .mem_wdata_o(wdat),
    .mem_we_o(we), .acc_o(acc), .zero_o(zero), .skip_o(skip), .done_o(done));

  iso_mem_model i_iso_mem_model (.clk_i(clk_i), .addr_i(madr), .wdata_i(wdat),
    .we_i(we), .rdata_o(rdat));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic issue(input iso_pkg::iso_op_t o, input logic d, input logic [7:0] a,
                       input logic [7:0] l);
    int n;
    @(negedge clk_i);
    vld = 1'b1;
    opc = o;
    dst = d;
    adr = a;
    lit = l;
    n = 0;
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (rdy !== 1'b1) begin
      bad_count++;
      $display("MISMATCH ready expected 1 seen %b", rdy);
    end
    @(negedge clk_i);
    vld = 1'b0;
    n = 0;
    while (done !== 1'b1 && skip !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (done !== 1'b1 && skip !== 1'b1) begin
      bad_count++;
      $display("MISMATCH done_or_skip expected 1 seen %b %b", done, skip);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_inc_acc();
    i_iso_mem_model.mem_q[8'h10] = 8'h23;
    issue(iso_pkg::iso_increment_operand_op, 1'b0, 8'h10, 8'h00);
    chk("acc", 8'h24, acc);
    chk("mem10", 8'h23, i_iso_mem_model.mem_q[8'h10]);
    chk("zero", 8'h00, zero);
    chk("done", 8'h01, done);
    chk("ready", 8'h01, rdy);
    chk("addr", 8'h10, madr);
  endtask

  task automatic t_inc_wrap();
    i_iso_mem_model.mem_q[8'h11] = 8'hFF;
    issue(iso_pkg::iso_increment_operand_op, 1'b1, 8'h11, 8'h00);
    chk("we", 8'h01, we);
    chk("wdata", 8'h00, wdat);
    @(negedge clk_i);
    chk("mem11", 8'h00, i_iso_mem_model.mem_q[8'h11]);
    chk("we", 8'h00, we);
    chk("done", 8'h00, done);
    chk("acc", 8'h24, acc);
    chk("zero", 8'h01, zero);
  endtask

  task automatic t_skip_nz();
    i_iso_mem_model.mem_q[8'h12] = 8'h05;
    issue(iso_pkg::iso_increment_skip_on_zero_op, 1'b0, 8'h12, 8'h00);
    chk("acc", 8'h06, acc);
    chk("skip", 8'h00, skip);
    chk("zero", 8'h01, zero);
    chk("done", 8'h01, done);
  endtask

  task automatic t_skip_zero();
    i_iso_mem_model.mem_q[8'h13] = 8'hFF;
    issue(iso_pkg::iso_increment_skip_on_zero_op, 1'b1, 8'h13, 8'h00);
    chk("skip", 8'h01, skip);
    chk("done", 8'h00, done);
    issue(iso_pkg::iso_or_literal_into_accumulator_op, 1'b0, 8'h00, 8'hF0);
    chk("done", 8'h01, done);
    chk("skip", 8'h00, skip);
    chk("mem13", 8'h00, i_iso_mem_model.mem_q[8'h13]);
    chk("acc", 8'h06, acc);
    chk("zero", 8'h01, zero);
  endtask

  task automatic t_or();
    issue(iso_pkg::iso_or_literal_into_accumulator_op, 1'b1, 8'h00, 8'h85);
    chk("acc", 8'h87, acc);
    chk("zero", 8'h00, zero);
    chk("skip", 8'h00, skip);
    chk("we", 8'h00, we);
    i_iso_mem_model.mem_q[8'h14] = 8'h14;
    issue(iso_pkg::iso_nop_op, 1'b1, 8'h14, 8'hFF);
    @(negedge clk_i);
    chk("mem14", 8'h14, i_iso_mem_model.mem_q[8'h14]);
    chk("acc", 8'h87, acc);
  endtask

  task automatic t_mid_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h00, zero);
    chk("ready", 8'h01, rdy);
    rst_n_i = 1'b1;
    issue(iso_pkg::iso_or_literal_into_accumulator_op, 1'b0, 8'h00, 8'h00);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h01, zero);
  endtask

  initial begin
    #10000;
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("acc", 8'h00, acc);
    chk("zero", 8'h00, zero);
    t_inc_acc();
    t_inc_wrap();
    t_skip_nz();
    t_skip_zero();
    t_or();
    t_mid_reset();
    end_of_test();
  end
endmodule
